// ---- hw/crcsd_defs.vh ----
// register offsets, resets and crc constants for the crc seed and capture block
`ifndef CRCSD_DEFS_VH
`define CRCSD_DEFS_VH
`define CRCSD_ADDR_SEED_LOW 8'h15
`define CRCSD_ADDR_SEED_HIGH 8'h16
`define CRCSD_ADDR_SENT_LOW 8'h17
`define CRCSD_ADDR_SENT_HIGH 8'h18
`define CRCSD_SEED_RESET 8'h00
`define CRCSD_SENT_RESET 8'h00
`define CRCSD_CRC_RESET 16'h0000
`define CRCSD_RDATA_IDLE 8'h00
`define CRCSD_POLY 16'h1021
`define CRCSD_MSB_FIRST 1'b1
`endif

// ---- hw/crcsd_engine.v ----
// crc16 accumulator, one data byte per step
`timescale 1ns/1ps
`include "crcsd_defs.vh"
module crcsd_engine #(
  parameter [15:0] POLY = `CRCSD_POLY,
  parameter MSB_FIRST = 1
) (
  input wire clock,
  input wire rst_n,
  input wire [15:0] seed,
  input wire start,
  input wire byte_valid,
  input wire [7:0] byte_data,
  output wire [15:0] crc
);
  reg [15:0] acc_q;
  reg [15:0] acc_d;
  reg [15:0] tmp;
  reg fb;
  integer i;

  always @* begin
    tmp = start ? seed : acc_q;
    fb = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      if (MSB_FIRST != 0) begin
        fb = tmp[15] ^ byte_data[7 - i];
        tmp = {tmp[14:0], 1'b0} ^ (fb ? POLY : 16'h0000);
      end else begin
        fb = tmp[0] ^ byte_data[i];
        tmp = {1'b0, tmp[15:1]} ^ (fb ? POLY : 16'h0000);
      end
    end
    acc_d = acc_q;
    if (byte_valid) begin
      acc_d = tmp;
    end else if (start) begin
      acc_d = seed;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= `CRCSD_CRC_RESET;
    end else begin
      acc_q <= acc_d;
    end
  end

  assign crc = acc_q;
endmodule

// ---- hw/crcsd_top.v ----
// crc16 seed registers, one crc engine each for tx and rx, sent-packet crc capture
// Functional notes
// - seed low byte loads accumulator low byte
// - seed high byte loads accumulator high byte
// - same seed for transmit and receive
// - sent crc low byte readable, read-only
// - sent crc high byte readable, read-only
`timescale 1ns/1ps
`include "crcsd_defs.vh"
module crcsd_top #(
  parameter [15:0] POLY = `CRCSD_POLY,
  parameter MSB_FIRST = 1
) (
  input wire clock,
  input wire rst_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_q,
  output reg reg_hit_q,
  input wire tx_start,
  input wire tx_byte_valid,
  input wire [7:0] tx_byte,
  input wire tx_done,
  output reg [15:0] tx_crc_q,
  input wire rx_start,
  input wire rx_byte_valid,
  input wire [7:0] rx_byte,
  output reg [15:0] rx_crc_q
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  // channel 0 generates, channel 1 checks
  localparam NCH = 2;
  localparam CH_TX = 0;
  localparam CH_RX = 1;

  reg [7:0] seed_low_q;
  reg [7:0] seed_low_d;
  reg [7:0] seed_high_q;
  reg [7:0] seed_high_d;
  reg [7:0] sent_low_q;
  reg [7:0] sent_low_d;
  reg [7:0] sent_high_q;
  reg [7:0] sent_high_d;
  reg [7:0] rdata_d;
  reg hit_d;
  reg [15:0] tx_crc_d;
  reg [15:0] rx_crc_d;
  wire [15:0] seed;
  wire [NCH-1:0] ch_start;
  wire [NCH-1:0] ch_valid;
  wire [8*NCH-1:0] ch_byte;
  wire [16*NCH-1:0] ch_acc;
  wire [15:0] tx_acc;
  wire [15:0] rx_acc;
  wire sel_seed_low;
  wire sel_seed_high;
  wire sel_sent_low;
  wire sel_sent_high;
  wire sel_any;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  assign sel_seed_low = (reg_addr == `CRCSD_ADDR_SEED_LOW);
  assign sel_seed_high = (reg_addr == `CRCSD_ADDR_SEED_HIGH);
  assign sel_sent_low = (reg_addr == `CRCSD_ADDR_SENT_LOW);
  assign sel_sent_high = (reg_addr == `CRCSD_ADDR_SENT_HIGH);
  assign sel_any = sel_seed_low | sel_seed_high | sel_sent_low | sel_sent_high;

  // ----------------------------------------
  // seed registers
  // ----------------------------------------
  // seed byte join
  assign seed = {seed_high_q, seed_low_q};

  always @* begin
    seed_low_d = seed_low_q;
    seed_high_d = seed_high_q;
    if (reg_wr && sel_seed_low) begin
      seed_low_d = reg_wdata;
    end
    if (reg_wr && sel_seed_high) begin
      seed_high_d = reg_wdata;
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seed_low_q <= `CRCSD_SEED_RESET;
      seed_high_q <= `CRCSD_SEED_RESET;
    end else begin
      seed_low_q <= seed_low_d;
      seed_high_q <= seed_high_d;
    end
  end

  // ----------------------------------------
  // crc engines
  // ----------------------------------------
  assign ch_start = {rx_start, tx_start};
  assign ch_valid = {rx_byte_valid, tx_byte_valid};
  assign ch_byte = {rx_byte, tx_byte};

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      crcsd_engine #(
        .POLY(POLY),
        .MSB_FIRST(MSB_FIRST)
      ) u_eng (
        .clock(clock),
        .rst_n(rst_n),
        .seed(seed),
        .start(ch_start[g]),
        .byte_valid(ch_valid[g]),
        .byte_data(ch_byte[8*g +: 8]),
        .crc(ch_acc[16*g +: 16])
      );
    end
  endgenerate

  assign tx_acc = ch_acc[16*CH_TX +: 16];
  assign rx_acc = ch_acc[16*CH_RX +: 16];

  // ----------------------------------------
  // accumulator outputs
  // ----------------------------------------
  // one cycle behind the accumulators
  always @* begin
    tx_crc_d = tx_acc;
    rx_crc_d = rx_acc;
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_crc_q <= `CRCSD_CRC_RESET;
      rx_crc_q <= `CRCSD_CRC_RESET;
    end else begin
      tx_crc_q <= tx_crc_d;
      rx_crc_q <= rx_crc_d;
    end
  end

  // ----------------------------------------
  // sent-packet capture
  // ----------------------------------------
  // capture at completion
  // a byte taken with tx_done is not included
  always @* begin
    sent_low_d = sent_low_q;
    sent_high_d = sent_high_q;
    if (tx_done) begin
      sent_low_d = tx_acc[7:0];
      sent_high_d = tx_acc[15:8];
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sent_low_q <= `CRCSD_SENT_RESET;
      sent_high_q <= `CRCSD_SENT_RESET;
    end else begin
      sent_low_q <= sent_low_d;
      sent_high_q <= sent_high_d;
    end
  end

  // ----------------------------------------
  // register read port
  // ----------------------------------------
  // read data holds until the next read
  always @* begin
    rdata_d = reg_rdata_q;
    hit_d = 1'b0;
    if (reg_rd) begin
      hit_d = sel_any;
      case (reg_addr)
        `CRCSD_ADDR_SEED_LOW: begin
          rdata_d = seed_low_q;
        end
        `CRCSD_ADDR_SEED_HIGH: begin
          rdata_d = seed_high_q;
        end
        `CRCSD_ADDR_SENT_LOW: begin
          rdata_d = sent_low_q;
        end
        `CRCSD_ADDR_SENT_HIGH: begin
          rdata_d = sent_high_q;
        end
        default: begin
          rdata_d = `CRCSD_RDATA_IDLE;
        end
      endcase
    end
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= `CRCSD_RDATA_IDLE;
      reg_hit_q <= 1'b0;
    end else begin
      reg_rdata_q <= rdata_d;
      reg_hit_q <= hit_d;
    end
  end
endmodule

// ---- test/crcsd_properties.sv ----
// read port and crc output hold checker
`timescale 1ns/1ps
module crcsd_properties (
  input wire clock,
  input wire rst_n,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_rdata_q,
  input wire reg_hit_q,
  input wire tx_start,
  input wire tx_byte_valid,
  input wire [15:0] tx_crc_q,
  input wire rx_start,
  input wire rx_byte_valid,
  input wire [15:0] rx_crc_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  read_hit_a: assert property (reg_rd |=> reg_hit_q == ($past(reg_addr) > 8'h14 && $past(reg_addr) < 8'h19))
    else $error("hit");
  hit_pulse_a: assert property (!reg_rd |=> !reg_hit_q)
    else $error("pulse");
  data_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data changed without a read");
  unmapped_read_a: assert property (reg_rd && (reg_addr < 8'h15 || reg_addr > 8'h18) |=> reg_rdata_q == 8'h00 && !reg_hit_q)
    else $error("unmapped read not zero");
  tx_crc_hold_a: assert property (!tx_start && !tx_byte_valid |=> ##1 $stable(tx_crc_q))
    else $error("tx crc moved while idle");
  rx_crc_hold_a: assert property (!rx_start && !rx_byte_valid |=> ##1 $stable(rx_crc_q))
    else $error("rx crc moved while idle");
endmodule
bind crcsd_top crcsd_properties u_chk (.*);

// ---- test/crcsd_host.sv ----
// host on the register port
`timescale 1ns/1ps
module crcsd_host (
  input wire clock,
  output reg reg_wr = 1'b0,
  output reg reg_rd = 1'b0,
  output reg [7:0] reg_addr = 8'h00,
  output reg [7:0] reg_wdata = 8'h00
);
  task acc(input w, input [7:0] a, input [7:0] d);
    @(posedge clock);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
endmodule

// ---- test/tb.sv ----
// crc seed block bench
`timescale 1ns/1ps
`include "crcsd_defs.vh"
module tb;
  reg clock = 1'b0, rst_n = 1'b0, tx_start = 1'b0, tx_byte_valid = 1'b0, tx_done = 1'b0;
  reg [7:0] tx_byte = 8'h00;
  wire reg_wr, reg_rd, reg_hit_q;
  wire [7:0] reg_addr, reg_wdata, reg_rdata_q;
  wire [15:0] tx_crc_q, rx_crc_q;
  localparam [79:0] ROWS = 80'h2000_1800_1700_163C_15A5;
  reg [15:0] e = 16'h3CA5;
  integer n_errors = 0, checks = 0, i, j;
  always #4 clock = ~clock;
  crcsd_host h (.*);
  crcsd_top DUT (.*, .rx_start(tx_start), .rx_byte_valid(tx_byte_valid), .rx_byte(tx_byte));
  task chk(input [15:0] s, input [15:0] x);
    checks++;
    if (s !== x) begin
      n_errors++;
      $display("[ERR] %0t %h %h", $time, s, x);
    end
  endtask
  task rd(input [7:0] a, input [7:0] x);
    h.acc(1'b0, a, 8'h00);
    @(negedge clock);
    chk({8'h00, reg_rdata_q}, {8'h00, x});
    chk({15'h0000, reg_hit_q}, {15'h0000, a >= `CRCSD_ADDR_SEED_LOW && a <= `CRCSD_ADDR_SENT_HIGH});
    @(posedge clock);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    h.acc(1'b1, 8'h15, 8'hA5);
    h.acc(1'b1, 8'h16, 8'h3C);
    h.acc(1'b1, 8'h17, 8'hFF);
    for (i = 0; i < 5; i++)
      rd(ROWS[i*16+8 +: 8], ROWS[i*16 +: 8]);
    tx_start <= 1'b1;
    for (i = 0; i < 3; i++) begin
      @(posedge clock);
      tx_start <= 1'b0;
      tx_byte_valid <= 1'b1;
      tx_byte <= 8'h31 + i[7:0];
      e[15:8] ^= 8'h31 + i[7:0];
      for (j = 0; j < 8; j++)
        e = e[15] ? (e << 1) ^ `CRCSD_POLY : e << 1;
    end
    @(posedge clock);
    tx_byte_valid <= 1'b0;
    tx_done <= 1'b1;
    @(posedge clock);
    tx_done <= 1'b0;
    #1 chk(rx_crc_q, e);
    chk(tx_crc_q, e);
    rd(8'h17, e[7:0]);
    rd(8'h18, e[15:8]);
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
    rd(8'h15, 8'h00);
    rd(8'h16, 8'h00);
    chk(rx_crc_q, 16'h0000);
    give_verdict;
  end
  initial begin
    #5000;
    n_errors++;
    give_verdict;
  end
endmodule
